// File: inc/cmd_cable_pkg.sv
// Constants shared by the drive-side command cable controller
`default_nettype none
package cmd_cable_pkg;
    // ==================================================
    // Clock and timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ACK_TIMEOUT_US = 500;
    localparam int ACK_TIMEOUT_CYC = (ACK_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
    localparam int PULSE_WIDTH_PS = 1250000;
    localparam int PULSE_CYC = PULSE_WIDTH_PS / CLK_PERIOD_PS;
    localparam int ADDR_SETUP_NS = 400;
    localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ==================================================
    // Format and codes
    localparam int SECTORS_PER_REV = 64;
    localparam logic [7:0] TIMEOUT_ERR_CODE = 8'h01;
    localparam logic [1:0] SHIFT_NOMINAL = 2'h0;
    localparam logic [1:0] SHIFT_EARLY = 2'h1;
    localparam logic [1:0] SHIFT_LATE = 2'h2;
    // ==================================================
    // Handshake states
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SETUP = 3'b001,
        HS_WAIT_ACK = 3'b010,
        HS_WAIT_DROP = 3'b011,
        HS_FAULT = 3'b100
    } hs_state_e;
endpackage : cmd_cable_pkg
`default_nettype wire

// File: rtl/cmd_cable_ctrl.sv
// Drive-side command cable handshake, gates, strobes, index and sector pulses
`default_nettype none
module cmd_cable_ctrl
    import cmd_cable_pkg::*;
#(
    parameter int TIMEOUT_CYC = ACK_TIMEOUT_CYC,  // No-answer wait in cycles
    parameter int SECTOR_COUNT = SECTORS_PER_REV  // Sectors per track
) (
    input wire logic clk_in,                 // 250 MHz clock
    input wire logic nrst_in,                // Async reset, active low
    input wire logic ce_in,                  // Clock enable
    // Drive micro unit side
    input wire logic xfer_req_in,            // Request one byte transfer
    input wire logic xfer_to_drive_in,       // 1: adapter to drive
    input wire logic [2:0] xfer_addr_in,     // Byte address
    input wire logic [7:0] xfer_wdata_in,    // Byte for the adapter
    input wire logic cmd_done_in,            // Current command fully processed
    output logic xfer_busy_out,              // Transfer in progress
    output logic xfer_done_out,              // Transfer completed, one cycle
    output logic [7:0] xfer_rdata_out,       // Byte taken from adapter
    output logic cmd_exec_out,               // Execute processed command, pulse
    output logic cmd_drop_out,               // Discard unprocessed command, pulse
    output logic fault_out,                  // Timeout fault, sticky
    output logic [7:0] err_code_out,         // Microcomputer detected error code
    input wire logic fault_clr_in,           // Clear fault and code
    // Command cable pins
    output logic bus_ready_out,              // Bus ready to adapter
    input wire logic ack_in,                 // Acknowledge from adapter
    output logic dir_to_drive_out,           // Direction line
    output logic [2:0] addr_out,             // Address lines
    input wire logic [7:0] bus_in,           // Bus from adapter
    output logic [7:0] bus_out,              // Bus to adapter
    output logic bus_oe_n_out,               // Bus output enable, low drives
    input wire logic read_gate_in,           // Read gate
    input wire logic write_gate_in,          // Write gate
    input wire logic early_strobe_in,        // Early strobe
    input wire logic late_strobe_in,         // Late strobe
    output logic index_out,                  // Index pulse
    output logic sector_out,                 // Sector pulse
    // Read/write channel and servo
    input wire logic nrz_read_in,            // Recovered read data
    output logic read_data_out,              // Read data to data cable
    output logic read_data_en_out,           // Read data driver enable
    output logic sep_lock_start_out,         // Start separator lock, pulse
    output logic [1:0] strobe_shift_out,     // Separator sampling shift
    input wire logic write_data_in,          // Write data from data cable
    output logic write_data_out,             // Data to write head
    output logic write_en_out,               // Write current enable
    input wire logic servo_mark_in,          // Servo sector mark, pulse
    input wire logic head_change_in,         // Head change in progress
    input wire logic on_cylinder_in          // On-cylinder status
);
    localparam int SEC_W = $clog2(SECTOR_COUNT);
    localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);
    localparam int PW_W = $clog2(PULSE_CYC + 1);
    localparam int SU_W = $clog2(ADDR_SETUP_CYC + 1);

    // ==================================================
    // Reset release
    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ==================================================
    // Pin input synchronisers, accepted when stages two and three agree
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, clean_ff, nxt_clean;
    assign pin_raw = {ack_in, read_gate_in, write_gate_in, early_strobe_in, late_strobe_in,
                      servo_mark_in};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_comb begin
                nxt_clean[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : clean_ff[gi];
            end
        end
    endgenerate
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            clean_ff <= '0;
        end else if (ce_in) begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            clean_ff <= nxt_clean;
        end
    end
    logic ack_s, rg_s, wg_s, es_s, ls_s, mark_s;
    assign {ack_s, rg_s, wg_s, es_s, ls_s, mark_s} = clean_ff;

    // ==================================================
    // Four-phase handshake with no-answer timeout
    hs_state_e hs_ff, nxt_hs;
    logic [TMO_W-1:0] tmo_ff, nxt_tmo;
    logic [SU_W-1:0] su_ff, nxt_su;
    logic dir_ff, nxt_dir, fault_ff, nxt_fault, done_ff, nxt_done;
    logic exec_ff, nxt_exec, drop_ff, nxt_drop;
    logic [2:0] addr_ff, nxt_addr;
    logic [7:0] wbyte_ff, nxt_wbyte, rbyte_ff, nxt_rbyte, code_ff, nxt_code;

    // Direction and address are held through a dialogue so the adapter sees stable lines
    always_comb begin
        nxt_hs = hs_ff;
        nxt_tmo = tmo_ff;
        nxt_su = su_ff;
        nxt_dir = dir_ff;
        nxt_addr = addr_ff;
        nxt_wbyte = wbyte_ff;
        nxt_rbyte = rbyte_ff;
        nxt_done = 1'b0;
        nxt_exec = 1'b0;
        nxt_drop = 1'b0;
        nxt_fault = fault_ff;
        nxt_code = code_ff;
        if (fault_clr_in) begin
            nxt_fault = 1'b0;
            nxt_code = 8'h00;
        end
        unique case (hs_ff)
            HS_IDLE: begin
                if (xfer_req_in && !ack_s) begin
                    nxt_dir = xfer_to_drive_in;
                    nxt_addr = xfer_addr_in;
                    nxt_wbyte = xfer_wdata_in;
                    nxt_su = SU_W'(ADDR_SETUP_CYC);
                    nxt_hs = HS_SETUP;
                end
            end
            HS_SETUP: begin
                if (su_ff == '0) begin
                    nxt_tmo = TMO_W'(TIMEOUT_CYC);
                    nxt_hs = HS_WAIT_ACK;
                end else begin
                    nxt_su = su_ff - SU_W'(1);
                end
            end
            HS_WAIT_ACK: begin
                if (ack_s) begin
                    if (dir_ff) begin
                        nxt_rbyte = bus_in;
                    end
                    nxt_hs = HS_WAIT_DROP;
                end else if (tmo_ff == '0) begin
                    nxt_hs = HS_FAULT;
                end else begin
                    nxt_tmo = tmo_ff - TMO_W'(1);
                end
            end
            HS_WAIT_DROP: begin
                if (!ack_s) begin
                    nxt_done = 1'b1;
                    nxt_hs = HS_IDLE;
                end
            end
            HS_FAULT: begin
                nxt_fault = 1'b1;
                nxt_code = TIMEOUT_ERR_CODE;
                nxt_exec = cmd_done_in;
                nxt_drop = !cmd_done_in;
                nxt_hs = HS_IDLE;
            end
            default: begin
                nxt_hs = HS_IDLE;
            end
        endcase
    end

    // Handshake registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hs_ff <= HS_IDLE;
            tmo_ff <= '0;
            su_ff <= '0;
            dir_ff <= 1'b0;
            addr_ff <= 3'h0;
            wbyte_ff <= 8'h00;
            rbyte_ff <= 8'h00;
            done_ff <= 1'b0;
            exec_ff <= 1'b0;
            drop_ff <= 1'b0;
            fault_ff <= 1'b0;
            code_ff <= 8'h00;
        end else if (ce_in) begin
            hs_ff <= nxt_hs;
            tmo_ff <= nxt_tmo;
            su_ff <= nxt_su;
            dir_ff <= nxt_dir;
            addr_ff <= nxt_addr;
            wbyte_ff <= nxt_wbyte;
            rbyte_ff <= nxt_rbyte;
            done_ff <= nxt_done;
            exec_ff <= nxt_exec;
            drop_ff <= nxt_drop;
            fault_ff <= nxt_fault;
            code_ff <= nxt_code;
        end
    end

    assign bus_ready_out = (hs_ff == HS_WAIT_ACK);
    assign dir_to_drive_out = dir_ff;
    assign addr_out = addr_ff;
    assign bus_out = wbyte_ff;
    // Drive the bus only for drive-to-adapter dialogues, never while adapter may drive
    assign bus_oe_n_out = dir_ff || (hs_ff == HS_IDLE) || (hs_ff == HS_FAULT);
    assign xfer_busy_out = (hs_ff != HS_IDLE);
    assign xfer_done_out = done_ff;
    assign xfer_rdata_out = rbyte_ff;
    assign cmd_exec_out = exec_ff;
    assign cmd_drop_out = drop_ff;
    assign fault_out = fault_ff;
    assign err_code_out = code_ff;

    // ==================================================
    // Read/write gating and strobe shift
    logic rg_d_ff, lock_ff, nxt_lock, rd_ff, nxt_rd, rden_ff, nxt_rden;
    logic wd_ff, nxt_wd, wen_ff, nxt_wen;
    logic [1:0] shift_ff, nxt_shift;
    always_comb begin
        nxt_lock = rg_s && !rg_d_ff;
        nxt_rden = rg_s;
        nxt_rd = rg_s ? nrz_read_in : 1'b0;
        nxt_wen = wg_s;
        nxt_wd = wg_s ? write_data_in : 1'b0;
        nxt_shift = SHIFT_NOMINAL;
        if (rg_s && es_s && !ls_s) begin
            nxt_shift = SHIFT_EARLY;
        end else if (rg_s && ls_s && !es_s) begin
            nxt_shift = SHIFT_LATE;
        end
    end
    // Data paths registered; one cycle latency is small against NRZ bit time
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rg_d_ff <= 1'b0;
            lock_ff <= 1'b0;
            rd_ff <= 1'b0;
            rden_ff <= 1'b0;
            wd_ff <= 1'b0;
            wen_ff <= 1'b0;
            shift_ff <= SHIFT_NOMINAL;
        end else if (ce_in) begin
            rg_d_ff <= rg_s;
            lock_ff <= nxt_lock;
            rd_ff <= nxt_rd;
            rden_ff <= nxt_rden;
            wd_ff <= nxt_wd;
            wen_ff <= nxt_wen;
            shift_ff <= nxt_shift;
        end
    end
    assign sep_lock_start_out = lock_ff;
    assign read_data_out = rd_ff;
    assign read_data_en_out = rden_ff;
    assign write_data_out = wd_ff;
    assign write_en_out = wen_ff;
    assign strobe_shift_out = shift_ff;

    // ==================================================
    // Index and sector pulse generation from servo marks
    logic mark_d_ff;
    logic [SEC_W-1:0] sec_ff, nxt_sec;
    logic [PW_W-1:0] pw_ff, nxt_pw;
    logic is_index_ff, nxt_is_index;
    logic index_ff, nxt_index, sector_ff, nxt_sector;
    logic mark_rise;
    assign mark_rise = mark_s && !mark_d_ff;
    always_comb begin
        nxt_sec = sec_ff;
        nxt_pw = pw_ff;
        nxt_is_index = is_index_ff;
        if (pw_ff != '0) begin
            nxt_pw = pw_ff - PW_W'(1);
        end
        if (mark_rise) begin
            nxt_sec = (sec_ff == SEC_W'(SECTOR_COUNT - 1)) ? '0 : sec_ff + SEC_W'(1);
            // Marks during a head change give no pulse but still advance the sector count; a running pulse still completes
            if (!head_change_in && pw_ff == '0) begin
                nxt_pw = PW_W'(PULSE_CYC);
                nxt_is_index = (nxt_sec == '0);
            end
        end
        // Kind and width load on one edge; registering the pins keeps them free of glitches
        nxt_index = (nxt_pw != '0) && nxt_is_index;
        nxt_sector = (nxt_pw != '0) && !nxt_is_index;
    end
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mark_d_ff <= 1'b0;
            sec_ff <= '0;
            pw_ff <= '0;
            is_index_ff <= 1'b0;
            index_ff <= 1'b0;
            sector_ff <= 1'b0;
        end else if (ce_in) begin
            mark_d_ff <= mark_s;
            sec_ff <= nxt_sec;
            pw_ff <= nxt_pw;
            is_index_ff <= nxt_is_index;
            index_ff <= nxt_index;
            sector_ff <= nxt_sector;
        end
    end
    assign index_out = index_ff;
    assign sector_out = sector_ff;

endmodule : cmd_cable_ctrl
`default_nettype wire

// File: dv/cmd_cable_sva.sv
// Checker for the command cable controller
`default_nettype none
module cmd_cable_sva
    import cmd_cable_pkg::*;
#(
    parameter int TIMEOUT_CYC = ACK_TIMEOUT_CYC  // No-answer wait
) (
    input wire logic clk_in,  // Clock
    input wire logic nrst_in,  // Reset
    input wire logic ack_in,  // Ack pin
    input wire logic read_gate_in,  // Read gate
    input wire logic write_gate_in,  // Write gate
    input wire logic cmd_done_in,  // Command processed
    input wire logic bus_ready_out,  // Bus ready
    input wire logic dir_to_drive_out,  // Direction
    input wire logic [2:0] addr_out,  // Address
    input wire logic bus_oe_n_out,  // Bus enable
    input wire logic fault_out,  // Fault
    input wire logic [7:0] err_code_out,  // Error code
    input wire logic cmd_exec_out,  // Execute
    input wire logic cmd_drop_out,  // Discard
    input wire logic read_data_en_out,  // Read enable
    input wire logic sep_lock_start_out,  // Lock start
    input wire logic [1:0] strobe_shift_out,  // Shift
    input wire logic write_en_out,  // Write enable
    input wire logic index_out,  // Index
    input wire logic sector_out  // Sector
);
    // ====================
    // Pin history spans the design's synchronisers; counters time pulses
    logic [5:0] ack_h_ff, rg_h_ff, wg_h_ff;
    logic [8:0] pw_ff;
    logic [16:0] rdy_ff;  // Wide enough for the full no-answer wait
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_h_ff <= '0;
            rg_h_ff <= '0;
            wg_h_ff <= '0;
            pw_ff <= '0;
            rdy_ff <= '0;
        end else begin
            ack_h_ff <= {ack_h_ff[4:0], ack_in};
            rg_h_ff <= {rg_h_ff[4:0], read_gate_in};
            wg_h_ff <= {wg_h_ff[4:0], write_gate_in};
            pw_ff <= (index_out || sector_out) ? pw_ff + 9'h1 : 9'h0;
            rdy_ff <= !bus_ready_out ? rdy_ff : ($rose(bus_ready_out) ? 17'h1 : rdy_ff + 17'h1);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ====================
    // Properties
    property p_rd_en; read_data_en_out |-> |rg_h_ff; endproperty
    a_rd_en: assert property (p_rd_en) else $error("read data without gate");
    property p_shift; strobe_shift_out != SHIFT_NOMINAL |-> |rg_h_ff; endproperty
    a_shift: assert property (p_shift) else $error("shift without read gate");
    property p_lock; sep_lock_start_out |-> |rg_h_ff ##1 !sep_lock_start_out; endproperty
    a_lock: assert property (p_lock) else $error("lock start misplaced");
    property p_wr; write_en_out |-> |wg_h_ff; endproperty
    a_wr: assert property (p_wr) else $error("write without gate");
    property p_rise; $rose(bus_ready_out) |-> !(|ack_h_ff) && addr_out == $past(addr_out, 8);
    endproperty
    a_rise: assert property (p_rise) else $error("ready rose badly");
    property p_fall; $fell(bus_ready_out) && !(|ack_h_ff) |=> fault_out; endproperty
    a_fall: assert property (p_fall) else $error("ready dropped without ack");
    property p_tmax; rdy_ff <= TIMEOUT_CYC + 2; endproperty
    a_tmax: assert property (p_tmax) else $error("ready held too long");
    property p_tmin; $rose(fault_out) |-> rdy_ff >= TIMEOUT_CYC - 2; endproperty
    a_tmin: assert property (p_tmin) else $error("fault too early");
    property p_code; $rose(fault_out) |-> err_code_out == TIMEOUT_ERR_CODE
        && cmd_exec_out == cmd_done_in && cmd_drop_out == !cmd_done_in; endproperty
    a_code: assert property (p_code) else $error("timeout effects wrong");
    property p_oe; !bus_oe_n_out |-> !dir_to_drive_out; endproperty
    a_oe: assert property (p_oe) else $error("bus driven toward drive");
    property p_pw; $fell(index_out || sector_out) |-> pw_ff == PULSE_CYC; endproperty
    a_pw: assert property (p_pw) else $error("pulse width wrong");
    property p_excl; !(index_out && sector_out); endproperty
    a_excl: assert property (p_excl) else $error("index and sector together");
    c_fault: cover property ($rose(fault_out));
    c_index: cover property ($fell(index_out));
    c_in: cover property ($rose(bus_ready_out) && dir_to_drive_out);
endmodule : cmd_cable_sva
bind cmd_cable_ctrl cmd_cable_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_cmd_cable_sva (
    .clk_in(clk_in), .nrst_in(nrst_in), .ack_in(ack_in), .read_gate_in(read_gate_in),
    .write_gate_in(write_gate_in), .cmd_done_in(cmd_done_in), .bus_ready_out(bus_ready_out),
    .dir_to_drive_out(dir_to_drive_out), .addr_out(addr_out), .bus_oe_n_out(bus_oe_n_out),
    .fault_out(fault_out), .err_code_out(err_code_out), .cmd_exec_out(cmd_exec_out),
    .cmd_drop_out(cmd_drop_out), .read_data_en_out(read_data_en_out),
    .sep_lock_start_out(sep_lock_start_out), .strobe_shift_out(strobe_shift_out),
    .write_en_out(write_en_out), .index_out(index_out), .sector_out(sector_out));
`default_nettype wire

// File: dv/adapter_model.sv
// Adapter model answering the drive's bus-ready handshake
`default_nettype none
module adapter_model (
    input wire logic clk_in,  // Clock
    input wire logic bus_ready_in,  // Bus ready from drive
    input wire logic dir_in,  // 1: byte to drive
    input wire logic [7:0] drv_byte_in,  // Drive's bus
    input wire logic [7:0] tx_byte_in,  // Byte to offer
    input wire logic [7:0] wait_in,  // Answer delay
    input wire logic mute_in,  // Never answer
    output logic ack_out,  // Acknowledge
    output logic [7:0] bus_out,  // Adapter bus
    output logic [7:0] got_out  // Byte taken
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus toggles so a stale byte is never mistaken for a fresh one
    initial begin
        ack_out = 1'b0;
        bus_out = 8'h00;
        got_out = 8'h00;
        forever begin
            @(posedge clk_in);
            if (bus_ready_in && !mute_in) begin
                repeat (wait_in) @(posedge clk_in);
                bus_out <= tx_byte_in;
                if (!dir_in) got_out <= drv_byte_in;
                ack_out <= 1'b1;
                while (bus_ready_in) @(posedge clk_in);
                ack_out <= 1'b0;
            end else begin
                bus_out <= ~bus_out;
            end
        end
    end
endmodule : adapter_model
`default_nettype wire

// File: dv/cmd_cable_ctrl_tb_top.sv
// Testbench for the command cable controller
`default_nettype none
module cmd_cable_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cmd_cable_pkg::*;
    logic clk_in = 0, nrst_in = 0, req = 0, to_drv = 0, cd = 0, clr = 0, mute = 0;
    logic rg = 0, wg = 0, es = 0, ls = 0, nrz = 0, wd = 0, mark = 0, hc = 0;
    logic [2:0] addr = 3'h0, ao;
    logic [7:0] wdata = 8'h00, tx = 8'h00, dly = 8'h00, rdata, code, bo, bi, got;
    logic busy, done, exec, drop, fault, rdy, dir, oe_n, idx, sec, rde, rdd, lock, wen, wdo, ack;
    logic [1:0] shift;
    logic [1:0] exp_sh [4] = '{SHIFT_NOMINAL, SHIFT_EARLY, SHIFT_LATE, SHIFT_NOMINAL};
    int miscompares = 0, tests_run = 0, cyc = 0, n_idx = 0, n_sec = 0, n_ex = 0, n_dr = 0;
    int n_lk = 0, i;
    cmd_cable_ctrl #(.TIMEOUT_CYC(200)) i_cmd_cable_ctrl (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .xfer_req_in(req),
        .xfer_to_drive_in(to_drv), .xfer_addr_in(addr), .xfer_wdata_in(wdata),
        .cmd_done_in(cd), .xfer_busy_out(busy), .xfer_done_out(done), .xfer_rdata_out(rdata),
        .cmd_exec_out(exec), .cmd_drop_out(drop), .fault_out(fault), .err_code_out(code),
        .fault_clr_in(clr), .bus_ready_out(rdy), .ack_in(ack), .dir_to_drive_out(dir),
        .addr_out(ao), .bus_in(bi), .bus_out(bo), .bus_oe_n_out(oe_n), .read_gate_in(rg),
        .write_gate_in(wg), .early_strobe_in(es), .late_strobe_in(ls), .index_out(idx),
        .sector_out(sec), .nrz_read_in(nrz), .read_data_out(rdd), .read_data_en_out(rde),
        .sep_lock_start_out(lock), .strobe_shift_out(shift), .write_data_in(wd),
        .write_data_out(wdo), .write_en_out(wen), .servo_mark_in(mark),
        .head_change_in(hc), .on_cylinder_in(1'b1));
    adapter_model i_adapter_model (.clk_in(clk_in), .bus_ready_in(rdy), .dir_in(dir),
        .drv_byte_in(bo), .tx_byte_in(tx), .wait_in(dly), .mute_in(mute), .ack_out(ack),
        .bus_out(bi), .got_out(got));
    // ====================
    // Clock, event counters and hang guard
    always #2 clk_in = ~clk_in;
    always @(posedge idx) n_idx++;
    always @(posedge sec) n_sec++;
    always @(posedge exec) n_ex++;
    always @(posedge drop) n_dr++;
    always @(posedge lock) n_lk++;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            finish_test();
        end
    end
    // ====================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    // One byte dialogue; the unused direction carries the inverse byte
    task automatic xfer(input logic d, input logic [2:0] a, input logic [7:0] b);
        int k;
        to_drv = d;
        addr = a;
        wdata = d ? ~b : b;
        tx = d ? b : ~b;
        req = 1;
        tick(1);
        req = 0;
        check({busy, dir, oe_n, ao}, {1'b1, d, d, a});
        for (k = 0; k < 2000 && done !== 1'b1; k++) tick(1);
        check(d ? rdata : got, b);
        check(busy, 1'b0);
    endtask : xfer
    // Unanswered dialogue ends on the fixed timeout
    task automatic silent(input logic c);
        int ex0, dr0;
        ex0 = n_ex;
        dr0 = n_dr;
        mute = 1;
        cd = c;
        req = 1;
        tick(1);
        req = 0;
        tick(360);
        check(fault, 1'b1);
        check(code, TIMEOUT_ERR_CODE);
        check({4'(n_ex - ex0), 4'(n_dr - dr0)}, c ? 8'h10 : 8'h01);
        mute = 0;
        clr = 1;
        tick(1);
        clr = 0;
        tick(3);
        check(fault, 1'b0);
        check(code, 8'h00);
    endtask : silent
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // ====================
    // Main sequence
    initial begin
        tick(8);
        nrst_in = 1;
        tick(4);
        xfer(1'b0, 3'h1, 8'ha5);
        xfer(1'b1, 3'h7, 8'h3c);
        dly = 8'h3c;
        xfer(1'b0, 3'h3, 8'h5a);
        dly = 8'h00;
        silent(1'b1);
        silent(1'b0);
        xfer(1'b1, 3'h5, 8'hc3);
        rg = 1;
        nrz = 1;
        tick(8);
        check({rde, rdd, n_lk[5:0]}, 8'hc1);
        for (i = 0; i < 4; i++) begin
            {ls, es} = i[1:0];
            tick(8);
            check(shift, exp_sh[i]);
        end
        rg = 0;
        ls = 0;
        tick(8);
        check({rde, rdd, shift}, 8'h00);
        es = 0;
        wg = 1;
        wd = 1;
        tick(8);
        check({wen, wdo}, 8'h03);
        wg = 0;
        tick(8);
        check(wen, 1'b0);
        // Marks 1 to 63 give sectors, the 64th the index; a head switch lands mid index
        for (i = 0; i < 65; i++) begin
            hc = (i == 64);
            mark = 1;
            tick(4);
            mark = 0;
            tick(60);
            hc = (i >= 63);
            tick(300);
        end
        hc = 0;
        check(n_sec[7:0], 8'h3f);
        check(n_idx[7:0], 8'h01);
        finish_test();
    end
endmodule : cmd_cable_ctrl_tb_top
`default_nettype wire
